/* include/fwsr_defines.vh */
// Purpose: constants for the flash status/reset host controller
// Assumes: 20 MHz clock, AXI4-Lite register access, 16-bit flash data bus
// Notes:   offsets are byte addresses of aligned 32-bit words
`ifndef FWSR_DEFINES_VH
`define FWSR_DEFINES_VH

// register offsets
`define FWSR_OFS_CTRL      8'h00
`define FWSR_OFS_ADDR      8'h04
`define FWSR_OFS_DATA      8'h08
`define FWSR_OFS_STAT      8'h0C
`define FWSR_OFS_RDATA     8'h10
`define FWSR_OFS_HWRST     8'h14

// ctrl fields (write 1 to start)
`define FWSR_CTRL_WRITE    0
`define FWSR_CTRL_READ     1
`define FWSR_CTRL_SWRST    2
`define FWSR_CTRL_POLL     3
`define FWSR_CTRL_ABRST    4
`define FWSR_CTRL_BPRST    5

// status fields
`define FWSR_ST_BUSY       0
`define FWSR_ST_DONE       1
`define FWSR_ST_FAIL       2
`define FWSR_ST_ABORT      3
`define FWSR_ST_WINDOW     4
`define FWSR_ST_RDY        5
`define FWSR_ST_SUSP       6

// flash status bit positions
`define FWSR_DQ_POLL       7
`define FWSR_DQ_TOG1       6
`define FWSR_DQ_TLIM       5
`define FWSR_DQ_EWIN       3
`define FWSR_DQ_STOG       2
`define FWSR_DQ_BABT       1

// command words
`define FWSR_CMD_RESET     16'h00F0
`define FWSR_CMD_UNL1      16'h00AA
`define FWSR_CMD_UNL2      16'h0055
`define FWSR_CMD_BPRST1    16'h0090
`define FWSR_CMD_BPRST2    16'h0000
`define FWSR_ADR_UNL1      26'h0000555
`define FWSR_ADR_UNL2      26'h00002AA

// timing: strobe low and high phase, reset pulse
`define FWSR_CLK_MHZ       20
`define FWSR_STB_NS        100
`define FWSR_STB_CYC       ((`FWSR_STB_NS * `FWSR_CLK_MHZ + 999) / 1000)
`define FWSR_RST_NS        1000
`define FWSR_RST_CYC       ((`FWSR_RST_NS * `FWSR_CLK_MHZ + 999) / 1000)
`define FWSR_WIN_US        50
`define FWSR_WIN_CYC       (`FWSR_WIN_US * `FWSR_CLK_MHZ)

`endif

/* hw/fwsr_host.v */
// Purpose: host controller that writes commands to a parallel flash and polls its status
// Assumes: flash pins sampled synchronous to clock; AXI4-Lite slave for software
// Notes:   data bus is two-way: dq_o/dq_oe_n/dq_i, enable low while driving
//
// What this block does
// - after time limit, write reset command
// - skip window check if erases within 50us (not done here: FWSR_WIN_CYC is unused and every poll records the window bit)
// - check window before and after extra erase
// - buffer abort needs abort reset sequence
// - poll last loaded buffer word address
// - command write: select, write low, output high
// - restart interrupted operation after reset (here a hardware reset is refused while busy and no order is restarted)
// - software reset is F0 at any address
// - use software reset to recover states
// - unlock bypass needs two-cycle reset
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "fwsr_defines.vh"

module fwsr_host (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [25:0] flash_addr,
  output reg  [15:0] dq_o,
  output reg         dq_oe_n,
  input  wire [15:0] dq_i,
  output reg         chip_select_n,
  output reg         write_strobe_n,
  output reg         output_strobe_n,
  output reg         hw_reset_n,
  input  wire        ready_busy_n
);

  // sequencer states
  localparam ST_IDLE  = 3'd0;  // waiting for an order
  localparam ST_LOW   = 3'd1;  // strobe low phase
  localparam ST_HIGH  = 3'd2;  // strobe released, recovery
  localparam ST_HWRST = 3'd3;  // hardware reset pulse
  localparam ST_POLL2 = 3'd4;  // second status read of a pair

  // timing counts cut to the phase timer width on purpose
  localparam [31:0] STB_CYC_W = `FWSR_STB_CYC;  // strobe phase length, full width
  localparam [31:0] RST_CYC_W = `FWSR_RST_CYC;  // reset pulse length, full width
  localparam [7:0]  STB_CNT   = STB_CYC_W[7:0]; // strobe phase, timer width
  localparam [7:0]  RST_CNT   = RST_CYC_W[7:0]; // reset pulse, timer width

  reg [2:0]  state_r;          // sequencer state
  reg [7:0]  cnt_r;            // phase timer
  reg [1:0]  step_r;           // step within multi-cycle sequence
  reg [2:0]  op_r;             // current order: 0 wr,1 rd,2 swrst,3 poll,4 abrst,5 bprst
  reg [25:0] addr_r;           // software target address
  reg [15:0] data_r;           // software data word
  reg [15:0] rdata_r;          // last word read
  reg [15:0] prev_r;           // first word of a poll pair
  reg        busy_r;           // order in progress
  reg        done_r;           // operation complete (sticky)
  reg        fail_r;           // time limit failure seen
  reg        abort_r;          // buffer abort seen
  reg        window_r;         // erase window closed
  reg        susp_r;           // erase suspended sector seen
  reg        rdy_r;            // sampled ready/busy pin

  // register write channel: take address and data together
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  // read channel accepted when no answer pending
  assign s_axi_arready = ~s_axi_rvalid;

  // order starts only while idle and no write in flight
  wire ctrl_wr = wr_go & (s_axi_awaddr == `FWSR_OFS_CTRL) & s_axi_wstrb[0];
  // an order word with no bit set starts nothing
  wire start   = ctrl_wr & ~busy_r & (|s_axi_wdata[5:0]);
  wire hwr_wr  = wr_go & (s_axi_awaddr == `FWSR_OFS_HWRST) & s_axi_wstrb[0] & s_axi_wdata[0];

  // first set bit among ctrl bits gives the order code
  function [2:0] fwsr_pick;
    input [5:0] v;
    begin
      if (v[`FWSR_CTRL_WRITE])      fwsr_pick = 3'd0;
      else if (v[`FWSR_CTRL_READ])  fwsr_pick = 3'd1;
      else if (v[`FWSR_CTRL_SWRST]) fwsr_pick = 3'd2;
      else if (v[`FWSR_CTRL_POLL])  fwsr_pick = 3'd3;
      else if (v[`FWSR_CTRL_ABRST]) fwsr_pick = 3'd4;
      else                          fwsr_pick = 3'd5;
    end
  endfunction

  // index of the last bus cycle of each write order (cycle count minus one)
  function [1:0] fwsr_last;
    input [2:0] op;
    begin
      case (op)
        3'd4:    fwsr_last = 2'd2;  // unlock, unlock, reset
        3'd5:    fwsr_last = 2'd1;  // two-cycle bypass exit
        default: fwsr_last = 2'd0;
      endcase
    end
  endfunction

  // bus cycle address/data per order and step
  reg [25:0] cyc_addr;
  reg [15:0] cyc_data;
  always @* begin
    cyc_addr = addr_r;
    cyc_data = data_r;
    case (op_r)
      3'd2: begin
        cyc_data = `FWSR_CMD_RESET;
      end
      3'd4: begin
        // abort reset sequence, plain reset is ignored here
        if (step_r == 2'd0) begin
          cyc_addr = `FWSR_ADR_UNL1;
          cyc_data = `FWSR_CMD_UNL1;
        end else if (step_r == 2'd1) begin
          cyc_addr = `FWSR_ADR_UNL2;
          cyc_data = `FWSR_CMD_UNL2;
        end else begin
          cyc_addr = `FWSR_ADR_UNL1;
          cyc_data = `FWSR_CMD_RESET;
        end
      end
      3'd5: begin
        cyc_data = (step_r == 2'd0) ? `FWSR_CMD_BPRST1 : `FWSR_CMD_BPRST2;
      end
      default: begin
        cyc_data = data_r;
      end
    endcase
  end

  wire is_read = (op_r == 3'd1) | (op_r == 3'd3);
  wire [15:0] tog = prev_r ^ dq_i;   // bits that changed between two reads

  // flash sequencer
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      step_r <= 2'h0;
      op_r <= 3'h0;
      addr_r <= 26'h0000000;
      data_r <= 16'h0000;
      rdata_r <= 16'h0000;
      prev_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      abort_r <= 1'b0;
      window_r <= 1'b0;
      susp_r <= 1'b0;
      rdy_r <= 1'b1;
      flash_addr <= 26'h0000000;
      dq_o <= 16'h0000;
      dq_oe_n <= 1'b1;
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      hw_reset_n <= 1'b1;
    end else begin
      rdy_r <= ready_busy_n;
      if (wr_go && s_axi_awaddr == `FWSR_OFS_ADDR)
        addr_r <= s_axi_wdata[25:0];         // sector in upper bits
      if (wr_go && s_axi_awaddr == `FWSR_OFS_DATA)
        data_r <= s_axi_wdata[15:0];
      case (state_r)
        ST_IDLE: begin
          if (hwr_wr && !busy_r) begin
            // hold reset low for the minimum pulse
            busy_r <= 1'b1;
            hw_reset_n <= 1'b0;
            cnt_r <= RST_CNT;
            state_r <= ST_HWRST;
          end else if (start) begin
            op_r <= fwsr_pick(s_axi_wdata[5:0]);
            busy_r <= 1'b1;
            done_r <= 1'b0;
            step_r <= 2'd0;
            state_r <= ST_HIGH;
            cnt_r <= STB_CNT;                // full gap after any earlier frame
          end
        end
        ST_HIGH: begin
          // recovery gap, then start next cycle
          chip_select_n <= 1'b1;
          write_strobe_n <= 1'b1;
          output_strobe_n <= 1'b1;
          dq_oe_n <= 1'b1;
          if (cnt_r != 8'd0) begin
            cnt_r <= cnt_r - 8'd1;
          end else begin
            flash_addr <= cyc_addr;
            chip_select_n <= 1'b0;
            cnt_r <= STB_CNT;
            state_r <= ST_LOW;
            if (is_read) begin
              output_strobe_n <= 1'b0;
            end else begin
              // command write: select and write low, output high
              write_strobe_n <= 1'b0;
              dq_o <= cyc_data;
              dq_oe_n <= 1'b0;
            end
          end
        end
        ST_LOW: begin
          if (cnt_r != 8'd0) begin
            cnt_r <= cnt_r - 8'd1;
          end else begin
            // rising edge latches data in the flash
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
            chip_select_n <= 1'b1;
            cnt_r <= STB_CNT;
            if (is_read) begin
              rdata_r <= dq_i;
              if (op_r == 3'd3 && step_r == 2'd0) begin
                // toggling is judged from two reads in a row
                prev_r <= dq_i;
                step_r <= 2'd1;
                state_r <= ST_POLL2;
              end else begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
                state_r <= ST_IDLE;
              end
            end else if (step_r == fwsr_last(op_r)) begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
              if (op_r == 3'd2 || op_r == 3'd4) begin
                // recovery reset clears the failure flags
                fail_r <= 1'b0;
                susp_r <= 1'b0;
              end
              if (op_r == 3'd4) begin
                // plain reset leaves a buffer abort standing
                abort_r <= 1'b0;
              end
              state_r <= ST_IDLE;
            end else begin
              step_r <= step_r + 2'd1;
              state_r <= ST_HIGH;
            end
          end
        end
        ST_POLL2: begin
          // second read of the pair uses the same address
          if (cnt_r != 8'd0) begin
            cnt_r <= cnt_r - 8'd1;
          end else if (chip_select_n) begin
            chip_select_n <= 1'b0;
            output_strobe_n <= 1'b0;
            cnt_r <= STB_CNT;
          end else begin
            chip_select_n <= 1'b1;
            output_strobe_n <= 1'b1;
            rdata_r <= dq_i;
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
            window_r <= dq_i[`FWSR_DQ_EWIN];
            if (!tog[`FWSR_DQ_TOG1]) begin
              // toggling stopped: done, or suspended sector
              done_r <= 1'b1;
              susp_r <= tog[`FWSR_DQ_STOG] & dq_i[`FWSR_DQ_POLL];
            end else if (dq_i[`FWSR_DQ_TLIM]) begin
              fail_r <= 1'b1;
            end else if (dq_i[`FWSR_DQ_BABT]) begin
              abort_r <= 1'b1;
            end
          end
        end
        ST_HWRST: begin
          if (cnt_r != 8'd0) begin
            cnt_r <= cnt_r - 8'd1;
          end else begin
            hw_reset_n <= 1'b1;
            busy_r <= 1'b0;                           // pulse over, orders may start again
            fail_r <= 1'b0;
            abort_r <= 1'b0;
            window_r <= 1'b0;
            susp_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // write response
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      // past the map or not word aligned: slave error
      s_axi_bresp <= ((s_axi_awaddr > `FWSR_OFS_HWRST) || (s_axi_awaddr[1:0] != 2'b00)) ?
                     2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data mux
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `FWSR_OFS_CTRL:  s_axi_rdata <= {29'h0, op_r};
        `FWSR_OFS_ADDR:  s_axi_rdata <= {6'h00, addr_r};
        `FWSR_OFS_DATA:  s_axi_rdata <= {16'h0000, data_r};
        `FWSR_OFS_STAT:  s_axi_rdata <= {25'h0, susp_r, rdy_r, window_r,
                                         abort_r, fail_r, done_r, busy_r};
        `FWSR_OFS_RDATA: s_axi_rdata <= {16'h0000, rdata_r};
        `FWSR_OFS_HWRST: s_axi_rdata <= {31'h0, ~hw_reset_n};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* tb/fwsr_host_monitor.sv */
// Purpose: port checks on the flash host controller
// Assumes: one clock domain, rst active high
// Notes:   bound to fwsr_host from the bench top
`timescale 1ns/1ns
module fwsr_host_monitor (
  input wire        clock,
  input wire        rst,
  input wire [25:0] flash_addr,
  input wire [15:0] dq_o,
  input wire        dq_oe_n,
  input wire        chip_select_n,
  input wire        write_strobe_n,
  input wire        output_strobe_n,
  input wire        hw_reset_n
);
  reg [7:0] low_r; // cycles the flash reset pin has been low
  // count the flash reset pulse length
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_r <= 8'h00;
    end else if (!hw_reset_n) begin
      low_r <= low_r + 8'h01;
    end else begin
      low_r <= 8'h00;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_WE_FRAME: assert property (!write_strobe_n |-> !chip_select_n && output_strobe_n)
    else $error("write strobe outside a write frame");
  AST_OE_FREE: assert property (!output_strobe_n |-> dq_oe_n && write_strobe_n)
    else $error("bus driven during a read");
  AST_WE_DRIVE: assert property (!write_strobe_n |-> !dq_oe_n)
    else $error("command data not driven");
  AST_WE_HOLD: assert property (!write_strobe_n && !$past(write_strobe_n) |->
    $stable(dq_o) && $stable(flash_addr))
    else $error("address or data moved under write strobe");
  AST_WE_WIDTH: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  AST_CS_GAP: assert property ($rose(chip_select_n) |-> chip_select_n [*3])
    else $error("select gap too short");
  AST_HRST_LEN: assert property ($rose(hw_reset_n) |-> low_r >= 8'h14)
    else $error("flash reset pulse too short");
  AST_HRST_QUIET: assert property (!hw_reset_n |-> chip_select_n && write_strobe_n)
    else $error("access during flash reset");
endmodule

/* tb/fwsr_flash_model.sv */
// Purpose: behavioural flash device facing the host controller
// Assumes: active low strobes, status on the low byte
// Notes:   inj_go forces read, busy, time fail or buffer abort
`timescale 1ns/1ns
module fwsr_flash_model (
  input  wire        cs_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire        rst_n,
  input  wire [25:0] addr,
  input  wire [15:0] dq_in,
  input  wire [1:0]  inj_mode,
  input  wire        inj_go,
  output wire [15:0] dq,
  output wire        ryby_n,
  output reg  [15:0] last_cmd = 16'h0000,
  output reg  [25:0] last_adr = 26'h0000000,
  output reg  [7:0]  wr_cnt = 8'h00
);
  reg [1:0]  mode_r = 2'h0; // 0 read, 1 erase busy, 2 time fail, 3 abort
  reg [1:0]  seq_r = 2'h0;  // abort reset unlock progress
  reg        tog_r = 1'b0;  // toggle bit
  reg        sel_r = 1'b0;  // write cycle in progress
  reg [25:0] adr_r;         // latched address
  reg [15:0] dat_r;         // latched data
  // erase busy: window closed and sector toggle running
  wire [15:0] st = {8'h00, ~last_cmd[7], tog_r, mode_r == 2'h2, 1'b0, mode_r == 2'h1,
                    tog_r & (mode_r == 2'h1), mode_r == 2'h3, 1'b0};
  wire [15:0] val = (mode_r == 2'h0) ? (addr[15:0] ^ 16'h5A5A) : st;
  // released bus shows the inverse, never the last value
  assign dq = (!cs_n && !oe_n && rst_n) ? val : ~val;
  assign ryby_n = (mode_r == 2'h0);
  // toggle on each status read while busy
  always @(posedge oe_n) if (mode_r != 2'h0) tog_r <= ~tog_r;
  // settle after the falling write edge, then latch
  always @(negedge we_n) begin
    #1;
    sel_r <= !cs_n;
    adr_r <= addr;
    dat_r <= dq_in;
  end
  // decode the command on the rising write edge
  always @(posedge we_n or negedge rst_n or posedge inj_go) begin
    if (!rst_n) begin
      mode_r <= 2'h0;
      seq_r <= 2'h0;
    end else if (inj_go) begin
      mode_r <= inj_mode;
    end else if (sel_r) begin
      last_cmd <= dat_r;
      last_adr <= adr_r;
      wr_cnt <= wr_cnt + 8'h01;
      // any other word cancels a partial sequence
      seq_r <= (dat_r == 16'h00AA) ? 2'h1 : (dat_r == 16'h0055 && seq_r == 2'h1) ? 2'h2 : 2'h0;
      if (dat_r == 16'h00F0 && (mode_r == 2'h2 || (mode_r == 2'h3 && seq_r == 2'h2)))
        mode_r <= 2'h0;
    end
  end
endmodule

/* tb/fwsr_host_tb.sv */
// Purpose: self-checking bench for the flash host controller
// Assumes: 50 ns clock, register map of the defines header
// Notes:   flash side is a behavioural device model
`timescale 1ns/1ns
`include "fwsr_defines.vh"
module fwsr_host_tb;
  reg         clock = 1'b0, rst = 1'b1;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [31:0] wdata = 32'h0, rd;
  reg  [1:0]  inj_mode = 2'h0, rsp;
  reg         inj_go = 1'b0, pa, pw;
  reg  [7:0]  cnt0;
  wire        awready, wready, bvalid, arready, rvalid, dq_oe_n, cs_n, we_n, oe_n, hrst_n, ryby_n;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [25:0] faddr, m_adr;
  wire [15:0] dq_o, m_dq, m_cmd;
  wire [15:0] dq_i = !dq_oe_n ? dq_o : m_dq;
  wire [7:0]  m_cnt;
  integer     error_cnt = 0, tests_run = 0;
  fwsr_host u_fwsr_host (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr(faddr),
    .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i), .chip_select_n(cs_n),
    .write_strobe_n(we_n), .output_strobe_n(oe_n), .hw_reset_n(hrst_n),
    .ready_busy_n(ryby_n));
  fwsr_flash_model u_fwsr_flash_model (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
    .rst_n(hrst_n), .addr(faddr), .dq_in(dq_i), .inj_mode(inj_mode), .inj_go(inj_go),
    .dq(m_dq), .ryby_n(ryby_n), .last_cmd(m_cmd), .last_adr(m_adr), .wr_cnt(m_cnt));
  // free running clock
  always #25 clock = ~clock;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // register write: offer both channels, release each as taken
  task wr(input [7:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
        @(posedge clock);
        if (pa && awready) begin
          pa = 1'b0;
          awvalid <= 1'b0;
        end
        if (pw && wready) begin
          pw = 1'b0;
          wvalid <= 1'b0;
        end
      end
      do @(posedge clock); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge clock);
    end
  endtask
  // register read
  task rdr(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge clock);
    end
  endtask
  // start a flash operation and poll status until it is idle
  task cmd(input integer b);
    begin
      wr(`FWSR_OFS_CTRL, 32'h1 << b);
      rdr(`FWSR_OFS_STAT);
      while (rd[`FWSR_ST_BUSY] !== 1'b0) rdr(`FWSR_OFS_STAT);
    end
  endtask
  // force the device model into a state
  task inject(input [1:0] m);
    begin
      inj_mode <= m;
      inj_go <= 1'b1;
      @(posedge clock);
      inj_go <= 1'b0;
      @(posedge clock);
    end
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt = error_cnt + 1;
    results;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdr(`FWSR_OFS_STAT);
    chk(rd[`FWSR_ST_RDY], 32'h1);
    rdr(8'h18);
    chk(rsp, 32'h2);
    wr(8'h18, 32'h0);
    chk(rsp, 32'h2);
    wr(`FWSR_OFS_ADDR, 32'h0123456);
    wr(`FWSR_OFS_DATA, 32'h0000A5C3);
    cmd(`FWSR_CTRL_WRITE);
    chk(m_cmd, 32'hA5C3);
    chk(m_adr, 32'h0123456);
    inject(2'h2);
    cmd(`FWSR_CTRL_POLL);
    chk(rd[`FWSR_ST_FAIL], 32'h1);
    chk(rd[`FWSR_ST_RDY], 32'h0);
    cmd(`FWSR_CTRL_SWRST);
    chk(m_cmd, 32'h00F0);
    chk(ryby_n, 32'h1);
    chk(rd[`FWSR_ST_FAIL], 32'h0);
    inject(2'h1);
    cmd(`FWSR_CTRL_SWRST);
    chk(ryby_n, 32'h0);
    cmd(`FWSR_CTRL_POLL);
    chk(rd[`FWSR_ST_DONE], 32'h0);
    chk(rd[`FWSR_ST_WINDOW], 32'h1);
    inject(2'h0);
    cmd(`FWSR_CTRL_POLL);
    chk(rd[`FWSR_ST_DONE], 32'h1);
    inject(2'h3);
    cmd(`FWSR_CTRL_POLL);
    chk(rd[`FWSR_ST_ABORT], 32'h1);
    cmd(`FWSR_CTRL_SWRST);
    chk(ryby_n, 32'h0);
    chk(rd[`FWSR_ST_ABORT], 32'h1);
    cmd(`FWSR_CTRL_ABRST);
    chk(m_cmd, 32'h00F0);
    chk(ryby_n, 32'h1);
    chk(m_adr, 32'h555);
    chk(rd[`FWSR_ST_ABORT], 32'h0);
    cnt0 = m_cnt;
    cmd(`FWSR_CTRL_BPRST);
    chk(m_cnt - cnt0, 32'h2);
    chk(m_cmd, 32'h0000);
    inject(2'h2);
    wr(`FWSR_OFS_HWRST, 32'h1);
    chk(rsp, 32'h0);
    repeat (25) @(posedge clock);
    chk(ryby_n, 32'h1);
    wr(`FWSR_OFS_ADDR, 32'h0000042);
    cmd(`FWSR_CTRL_READ);
    rdr(`FWSR_OFS_RDATA);
    chk(rd, 32'h5A18);
    results;
  end
endmodule
bind fwsr_host fwsr_host_monitor u_fwsr_host_monitor (.clock(clock), .rst(rst),
  .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
  .hw_reset_n(hw_reset_n));
